// [rtl/fan_pkg.sv]
// Constants shared by the fan drive and tachometer logic.
// Assumes byte-wide registers on an 8-bit register address.
package fan_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DUTY = 8'h56;
  localparam logic [7:0] ADDR_CFG = 8'h58;
  localparam logic [7:0] ADDR_RESULT = 8'h59;
  localparam logic [7:0] ADDR_PRELOAD = 8'h5B;

  // Reset values, taken on the standby power-on reset
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h10;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] PRELOAD_RST = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // Field positions of the duty register
  localparam int DUTY_CTL_BIT = 0;
  localparam int DUTY_LO = 1;
  localparam int DUTY_HI = 6;
  localparam int CLK_SEL_BIT = 7;

  // Field positions of the clock config register
  localparam int SRC_BIT = 0;
  localparam int MULT_BIT = 2;
  localparam int DIV_LO = 4;
  localparam int DIV_HI = 5;

  // Divider widths and default step periods in clk cycles
  localparam int PERIOD_W = 16;
  localparam logic [15:0] STEP_PERIOD_0 = 16'h0080;
  localparam logic [15:0] STEP_PERIOD_1 = 16'h0040;
  localparam logic [15:0] STEP_PERIOD_2 = 16'h0020;
  localparam logic [15:0] STEP_PERIOD_3 = 16'h0010;
  localparam logic [15:0] TACH_BASE_PERIOD = 16'h0004;

  // Duty period and counter limits
  localparam logic [5:0] PHASE_LAST = 6'h3F;
  localparam logic [5:0] PHASE_FIRST = 6'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [1:0] DIV_BY_2 = 2'h1;

endpackage

// [rtl/fan_tick_gen.sv]
// Programmable tick divider: one-cycle tick every period clocks.
// Assumes period and restart come from logic on the same clock.
`timescale 1ns/1ps
module fan_tick_gen #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] period,
  input wire logic restart,
  output logic tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t st_r;
  tick_state_t st_nxt;

  // Period of 0 or 1 gives a tick on every clock
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (restart) begin
      st_nxt.cnt = '0;
    end else if ((W+1)'(st_r.cnt) + (W+1)'(1) >= (W+1)'(period)) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

  // Gap between ticks, watched only by the check below
  logic [W:0] gap_r;
  logic gap_ok_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_r <= '0;
      gap_ok_r <= 1'b0;
    end else begin
      gap_r <= st_r.tick ? '0 : gap_r + (W+1)'(1);
      gap_ok_r <= (gap_ok_r | st_r.tick) & ~restart & (period == $past(period)) & (period > W'(1));
    end
  end

  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (reset)
    (tick && gap_ok_r && $stable(period)) |-> (gap_r + (W+1)'(1) == (W+1)'(period)))
    else $error("tick spacing differs from period");

endmodule

// [rtl/fan_pin_sync.sv]
// Two-flop synchroniser for the tachometer pin with rise detect.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module fan_pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic rise
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // Edge detect compares the second flop with its delayed copy, never the first flop
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pin;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
    st_nxt.rise = st_r.sync & ~st_r.prev;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise = st_r.rise;

  AST_RISE_SINGLE: assert property (@(posedge clk) disable iff (reset)
    rise |=> !rise)
    else $error("rise pulse longer than one cycle");

endmodule

// [rtl/fan_pwm_and_tach_monitor.sv]
// Fan drive generator and tachometer monitor with its registers.
// Assumes a same-clock register port and an asynchronous tach pin.
// Contract
// - Duty control bit set forces the fan pin high, clear lets the duty field rule it.
// - Duty field maps linearly: zero is low, top bit alone is half, all ones is 63 high and 1 low.
// - Output rate is picked by the clock select, clock source and multiplier bits together.
// - Multiplier set doubles the selected output rate, clear leaves it alone.
// - Count divisor field prescales the tach count clock by 1, 2, 4 or 8 and resets to 2.
// - Each tach pulse is measured in internal clock counts into a read-only 8-bit value.
// - The result holds the final count of the previous pulse and stays still meanwhile.
// - The preload value is the starting count of every measurement.
// - Writing the preload register restarts the running count.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module fan_pwm_and_tach_monitor #(
  parameter logic [15:0] STEP_PERIOD_0 = fan_pkg::STEP_PERIOD_0,
  parameter logic [15:0] STEP_PERIOD_1 = fan_pkg::STEP_PERIOD_1,
  parameter logic [15:0] STEP_PERIOD_2 = fan_pkg::STEP_PERIOD_2,
  parameter logic [15:0] STEP_PERIOD_3 = fan_pkg::STEP_PERIOD_3,
  parameter logic [15:0] TACH_BASE_PERIOD = fan_pkg::TACH_BASE_PERIOD
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic fan_tach_pin,
  output logic fan_drive
);

  localparam int PW = fan_pkg::PERIOD_W;

  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] cfg;
    logic [7:0] result;
    logic [7:0] preload;
    logic [7:0] count;
    logic [5:0] phase;
    logic drive;
    logic [7:0] rdata;
  } fan_state_t;

  fan_state_t st_r;
  fan_state_t st_nxt;

  logic step_tick;
  logic tach_tick;
  logic tach_rise;
  logic [PW-1:0] step_base;
  logic [PW-1:0] step_period;
  logic [PW-1:0] tach_period;
  logic [1:0] rate_sel;
  logic [1:0] div_code;
  logic [5:0] duty_field;
  logic force_high;
  logic wr_duty;
  logic wr_cfg;
  logic wr_preload;
  logic step_restart;
  logic tach_restart;

  // Register write decode
  assign wr_duty = reg_wr && (reg_addr == fan_pkg::ADDR_DUTY);
  assign wr_cfg = reg_wr && (reg_addr == fan_pkg::ADDR_CFG);
  assign wr_preload = reg_wr && (reg_addr == fan_pkg::ADDR_PRELOAD);

  // Field views; reserved config bits are never looked at
  assign force_high = st_r.duty[fan_pkg::DUTY_CTL_BIT];
  assign duty_field = st_r.duty[fan_pkg::DUTY_HI:fan_pkg::DUTY_LO];
  assign rate_sel = {st_r.cfg[fan_pkg::SRC_BIT], st_r.duty[fan_pkg::CLK_SEL_BIT]};
  assign div_code = st_r.cfg[fan_pkg::DIV_HI:fan_pkg::DIV_LO];

  // Base step period from source and select bits
  always_comb begin
    case (rate_sel)
      2'h0: step_base = STEP_PERIOD_0;
      2'h1: step_base = STEP_PERIOD_1;
      2'h2: step_base = STEP_PERIOD_2;
      2'h3: step_base = STEP_PERIOD_3;
      default: step_base = STEP_PERIOD_0;
    endcase
  end

  // Halving the step period doubles the output rate
  assign step_period = st_r.cfg[fan_pkg::MULT_BIT] ? (step_base >> 1) : step_base;

  // Tach count clock: base period times 1, 2, 4 or 8
  assign tach_period = TACH_BASE_PERIOD << div_code;

  // Restart the step divider when its rate may change, so no long gap appears
  assign step_restart = wr_duty | wr_cfg;

  // Measurement window opens on each rise or on a preload write
  assign tach_restart = tach_rise | wr_preload;

  fan_tick_gen #(
    .W(PW)
  ) u_step_tick (
    .clk(clk),
    .reset(reset),
    .period(step_period),
    .restart(step_restart),
    .tick(step_tick)
  );

  fan_tick_gen #(
    .W(PW)
  ) u_tach_tick (
    .clk(clk),
    .reset(reset),
    .period(tach_period),
    .restart(tach_restart),
    .tick(tach_tick)
  );

  fan_pin_sync u_tach_sync (
    .clk(clk),
    .reset(reset),
    .pin(fan_tach_pin),
    .rise(tach_rise)
  );

  // Next state of registers, duty generator and tach counter
  always_comb begin
    st_nxt = st_r;

    // Software writes; the result register ignores writes
    if (wr_duty) begin
      st_nxt.duty = reg_wdata;
    end
    if (wr_cfg) begin
      st_nxt.cfg = reg_wdata;
    end
    if (wr_preload) begin
      st_nxt.preload = reg_wdata;
    end

    // Phase walks 0..63 and wraps, one step per tick
    if (step_tick) begin
      if (st_r.phase == fan_pkg::PHASE_LAST) begin
        st_nxt.phase = fan_pkg::PHASE_FIRST;
      end else begin
        st_nxt.phase = st_r.phase + 6'h01;
      end
    end

    // High while phase is below the duty field; force wins
    if (force_high) begin
      st_nxt.drive = 1'b1;
    end else begin
      st_nxt.drive = (st_r.phase < duty_field);
    end

    // Tach counting: a preload write beats a pulse edge in the same cycle
    if (wr_preload) begin
      st_nxt.count = reg_wdata;
    end else if (tach_rise) begin
      st_nxt.result = st_r.count;
      st_nxt.count = st_r.preload;
    end else if (tach_tick && (st_r.count != fan_pkg::COUNT_MAX)) begin
      st_nxt.count = st_r.count + 8'h01;
    end

    // Read data stands one cycle only, zero otherwise and when unmapped
    st_nxt.rdata = fan_pkg::RDATA_IDLE;
    if (reg_rd) begin
      case (reg_addr)
        fan_pkg::ADDR_DUTY: st_nxt.rdata = st_r.duty;
        fan_pkg::ADDR_CFG: st_nxt.rdata = st_r.cfg;
        fan_pkg::ADDR_RESULT: st_nxt.rdata = st_r.result;
        fan_pkg::ADDR_PRELOAD: st_nxt.rdata = st_r.preload;
        default: st_nxt.rdata = fan_pkg::RDATA_IDLE;
      endcase
    end
  end

  // State register; all fields take their reset values together
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.duty <= fan_pkg::DUTY_RST;
      st_r.cfg <= fan_pkg::CFG_RST;
      st_r.result <= fan_pkg::RESULT_RST;
      st_r.preload <= fan_pkg::PRELOAD_RST;
      st_r.count <= fan_pkg::PRELOAD_RST;
      st_r.phase <= fan_pkg::PHASE_FIRST;
      st_r.drive <= 1'b0;
      st_r.rdata <= fan_pkg::RDATA_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign fan_drive = st_r.drive;
  assign reg_rdata = st_r.rdata;

  // Named steps used by the checks below
  sequence preload_write;
    reg_wr && (reg_addr == fan_pkg::ADDR_PRELOAD);
  endsequence

  sequence pulse_edge;
    tach_rise && !wr_preload;
  endsequence

  sequence forced_on;
    force_high && !wr_duty;
  endsequence

  AST_FORCE_HIGH: assert property (@(posedge clk) disable iff (reset)
    forced_on ##1 forced_on |=> fan_drive)
    else $error("fan pin not held high while forced");

  AST_DUTY_ZERO: assert property (@(posedge clk) disable iff (reset)
    (!force_high && duty_field == 6'h00) |=> !fan_drive)
    else $error("fan pin high with zero duty");

  AST_DUTY_LEVEL: assert property (@(posedge clk) disable iff (reset)
    !force_high |=> (fan_drive == ($past(st_r.phase) < $past(duty_field))))
    else $error("fan pin level disagrees with phase and duty");

  AST_PHASE_WRAP: assert property (@(posedge clk) disable iff (reset)
    (step_tick && st_r.phase == fan_pkg::PHASE_LAST) |=> (st_r.phase == fan_pkg::PHASE_FIRST))
    else $error("phase did not wrap after 64 steps");

  AST_PHASE_STILL: assert property (@(posedge clk) disable iff (reset)
    !step_tick |=> $stable(st_r.phase))
    else $error("phase moved without a step");

  AST_MULT_PERIOD: assert property (@(posedge clk) disable iff (reset)
    st_r.cfg[fan_pkg::MULT_BIT] |-> (step_period == (step_base >> 1)))
    else $error("multiplier did not halve step period");

  AST_DIV_RESET: assert property (@(posedge clk)
    $fell(reset) |-> (div_code == fan_pkg::DIV_BY_2))
    else $error("count divisor not divide-by-2 after reset");

  AST_RESULT_LATCH: assert property (@(posedge clk) disable iff (reset)
    pulse_edge |=> (st_r.result == $past(st_r.count)))
    else $error("result not latched from final count");

  AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (reset)
    !tach_rise ##1 !tach_rise |-> $stable(st_r.result))
    else $error("result changed between pulses");

  AST_START_PRELOAD: assert property (@(posedge clk) disable iff (reset)
    pulse_edge |=> (st_r.count == $past(st_r.preload)))
    else $error("count did not start from preload");

  AST_PRELOAD_RESTART: assert property (@(posedge clk) disable iff (reset)
    preload_write |=> (st_r.count == $past(reg_wdata)) && (st_r.preload == $past(reg_wdata)))
    else $error("preload write did not restart count");

  AST_SATURATE: assert property (@(posedge clk) disable iff (reset)
    (st_r.count == fan_pkg::COUNT_MAX && !tach_rise && !wr_preload) |=> (st_r.count == fan_pkg::COUNT_MAX))
    else $error("tach count wrapped");

  AST_RESERVED_IDLE: assert property (@(posedge clk) disable iff (reset)
    (wr_cfg && reg_wdata[5:4] == div_code && reg_wdata[2:0] == st_r.cfg[2:0]) |=> $stable(tach_period) && $stable(step_period))
    else $error("reserved config bits changed behaviour");

  AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
    !reg_rd |=> (reg_rdata == fan_pkg::RDATA_IDLE))
    else $error("read data stood outside its cycle");

  // Further named steps for the force and count checks
  sequence duty_force_write;
    reg_wr && (reg_addr == fan_pkg::ADDR_DUTY) && reg_wdata[fan_pkg::DUTY_CTL_BIT];
  endsequence

  sequence count_advance;
    tach_tick && !tach_rise && !wr_preload && (st_r.count != fan_pkg::COUNT_MAX);
  endsequence

  // Force shows two clocks after the write, never a whole step later
  AST_FORCE_PROMPT: assert property (@(posedge clk) disable iff (reset)
    duty_force_write ##1 !wr_duty |=> fan_drive)
    else $error("fan pin slow to go high after force write");

  AST_DUTY_FULL: assert property (@(posedge clk) disable iff (reset)
    (!force_high && (&duty_field) && st_r.phase == fan_pkg::PHASE_LAST) |=> !fan_drive)
    else $error("fan pin high in the last step at full duty");

  AST_PHASE_STEP: assert property (@(posedge clk) disable iff (reset)
    (step_tick && st_r.phase != fan_pkg::PHASE_LAST) |=> (st_r.phase == $past(st_r.phase) + 6'h01))
    else $error("phase did not advance by one step");

  AST_NO_MULT: assert property (@(posedge clk) disable iff (reset)
    !st_r.cfg[fan_pkg::MULT_BIT] |-> (step_period == step_base))
    else $error("step period changed without the multiplier");

  AST_STEP_RESTART: assert property (@(posedge clk) disable iff (reset)
    step_restart |=> !step_tick)
    else $error("step tick right after a rate change");

  AST_DIV_ONE: assert property (@(posedge clk) disable iff (reset)
    (div_code == 2'h0) |-> (tach_period == TACH_BASE_PERIOD))
    else $error("divide-by-one count clock was scaled");

  // Tach counter counts up only on its own tick, and only by one
  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (reset)
    count_advance |=> (st_r.count == $past(st_r.count) + 8'h01))
    else $error("tach count did not advance by one");

  AST_COUNT_STILL: assert property (@(posedge clk) disable iff (reset)
    (!tach_tick && !tach_rise && !wr_preload) |=> $stable(st_r.count))
    else $error("tach count moved without a tick");

  AST_TACH_RESTART: assert property (@(posedge clk) disable iff (reset)
    tach_restart |=> !tach_tick)
    else $error("count tick right after a restart");

  AST_PRELOAD_WINS: assert property (@(posedge clk) disable iff (reset)
    (tach_rise && wr_preload) |=> $stable(st_r.result))
    else $error("result latched during a preload write");

  // Register port: writes land next cycle, the result takes no write
  AST_DUTY_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_duty |=> (st_r.duty == $past(reg_wdata)))
    else $error("duty write did not land");

  AST_CFG_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_cfg |=> (st_r.cfg == $past(reg_wdata)))
    else $error("config write did not land");

  AST_RESULT_RO: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == fan_pkg::ADDR_RESULT && !tach_rise) |=> $stable(st_r.result))
    else $error("result changed by a write");

  AST_READ_RESULT: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == fan_pkg::ADDR_RESULT) |=> (reg_rdata == $past(st_r.result)))
    else $error("result read back wrong");

  AST_READ_PRELOAD: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == fan_pkg::ADDR_PRELOAD) |=> (reg_rdata == $past(st_r.preload)))
    else $error("preload read back wrong");

  AST_RESET_OUT: assert property (@(posedge clk)
    $fell(reset) |-> (!fan_drive && reg_rdata == fan_pkg::RDATA_IDLE))
    else $error("outputs not idle after reset");

endmodule

// [sim/fan_model.sv]
// Cooling fan tachometer model: one rising edge per period clocks.
// Assumes period stays at 2 or more; pin rests low while disabled.
`timescale 1ns/1ps
module fan_model (
  input wire logic clk,
  input wire logic en,
  input wire logic [7:0] period,
  output logic fan_tach_pin
);
  logic [7:0] cnt_r;

  initial begin
    cnt_r = 8'h00;
    fan_tach_pin = 1'b0;
  end

  // Pin moves 1 ns after the edge, as an unrelated fan would
  always @(posedge clk) begin
    if (!en) begin
      cnt_r <= 8'h00;
      fan_tach_pin <= #1 1'b0;
    end else begin
      cnt_r <= (cnt_r + 8'h01 >= period) ? 8'h00 : cnt_r + 8'h01;
      fan_tach_pin <= #1 (cnt_r < (period >> 1));
    end
  end
endmodule

// [sim/tb.sv]
// Self-checking bench for the fan drive and tachometer block.
// Assumes short step periods so each drive period is a few hundred clocks.
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] SP0 = 16'h0004;
  localparam logic [15:0] SP1 = 16'h0006;
  localparam logic [15:0] SP2 = 16'h0008;
  localparam logic [15:0] SP3 = 16'h000A;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] period = 8'h10;
  logic [7:0] reg_rdata;
  logic fan_tach_pin;
  logic fan_drive;
  int bad_count = 0;
  int n_compared = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  fan_pwm_and_tach_monitor #(.STEP_PERIOD_0(SP0), .STEP_PERIOD_1(SP1), .STEP_PERIOD_2(SP2),
    .STEP_PERIOD_3(SP3), .TACH_BASE_PERIOD(16'h0002)) dut_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fan_tach_pin(fan_tach_pin), .fan_drive(fan_drive));

  fan_model model_u (.clk(clk), .en(en), .period(period), .fan_tach_pin(fan_tach_pin));

  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // Clocks per duty step for a config and duty pair
  function automatic int stepf(input logic [7:0] c, input logic [7:0] d);
    logic [15:0] p;
    case ({c[0], d[7]})
      2'b00: p = SP0;
      2'b01: p = SP1;
      2'b10: p = SP2;
      default: p = SP3;
    endcase
    return int'(p) >> c[2];
  endfunction

  // Settle two periods, then watch exactly two periods, sampled after each edge;
  // rising edges pin the step rate, which a duty ratio alone would not
  task automatic pwm(input logic [7:0] c, input logic [7:0] d);
    int s;
    int hi;
    int ex;
    int ups;
    int eu;
    logic prev;
    s = stepf(c, d);
    ex = d[0] ? 128 * s : 2 * int'(d[6:1]) * s;
    eu = (d[0] || d[6:1] == 6'h00) ? 0 : 2;
    hi = 0;
    ups = 0;
    wr(fan_pkg::ADDR_CFG, c);
    wr(fan_pkg::ADDR_DUTY, d);
    repeat (128 * s) @(posedge clk);
    #1;
    prev = fan_drive;
    repeat (128 * s) begin
      @(posedge clk);
      #1;
      hi += (fan_drive === 1'b1) ? 1 : 0;
      ups += (fan_drive === 1'b1 && prev === 1'b0) ? 1 : 0;
      prev = fan_drive;
    end
    chk("fan_drive high clocks", 16'(hi), 16'(ex));
    chk("fan_drive rising edges", 16'(ups), 16'(eu));
  endtask

  // Half a tick plus one clock covers the divider's start latency
  task automatic tach(input int t, input logic [7:0] exp);
    int p;
    p = t * 10 + t / 2 + 1;
    period <= 8'(p);
    en <= 1'b1;
    repeat (4 * p) @(posedge clk);
    rd(fan_pkg::ADDR_RESULT, exp);
  endtask

  // Main sequence
  initial begin
    logic [7:0] c;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(fan_pkg::ADDR_DUTY, fan_pkg::DUTY_RST);
    rd(fan_pkg::ADDR_CFG, 8'h10);
    rd(fan_pkg::ADDR_RESULT, 8'h00);
    rd(fan_pkg::ADDR_PRELOAD, 8'h00);
    rd(8'h57, 8'h00);
    wr(fan_pkg::ADDR_RESULT, 8'hAA);
    rd(fan_pkg::ADDR_RESULT, 8'h00);
    wr(fan_pkg::ADDR_PRELOAD, 8'h05);
    rd(fan_pkg::ADDR_PRELOAD, 8'h05);
    // Default divisor of two gives a tick every 4 clocks
    tach(4, 8'h0F);
    wr(fan_pkg::ADDR_CFG, 8'hCA);
    rd(fan_pkg::ADDR_CFG, 8'hCA);
    // All clock select, source and multiplier combinations, reserved bits set
    for (int i = 0; i < 8; i++) begin
      c = {2'b11, 2'b00, 1'b1, i[1], 1'b1, i[0]};
      pwm(c, {i[2], 6'h20, 1'b0});
    end
    pwm(8'hCA, 8'h00);
    pwm(8'hCA, 8'h02);
    pwm(8'hCA, 8'h7E);
    pwm(8'hCA, 8'h01);
    pwm(8'hCA, 8'h81);
    // Every divisor code
    for (int k = 0; k < 4; k++) begin
      wr(fan_pkg::ADDR_CFG, {2'b00, 2'(k), 4'h0});
      tach(2 << k, 8'h0F);
    end
    wr(fan_pkg::ADDR_PRELOAD, 8'h20);
    tach(16, 8'h2A);
    wr(fan_pkg::ADDR_PRELOAD, 8'hF8);
    tach(16, 8'hFF);
    repeat (50) @(posedge clk);
    rd(fan_pkg::ADDR_RESULT, 8'hFF);
    // Second reset mid-run; fan stopped in the same cycle so no pulse lands in the result
    @(posedge clk);
    en <= 1'b0;
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(fan_pkg::ADDR_CFG, fan_pkg::CFG_RST);
    rd(fan_pkg::ADDR_RESULT, fan_pkg::RESULT_RST);
    rd(fan_pkg::ADDR_PRELOAD, fan_pkg::PRELOAD_RST);
    chk("fan_drive after reset", {15'h0000, fan_drive}, 16'h0000);
    final_report();
  end
endmodule
